// [rtl/ffh_pkg.sv]
// ffh_pkg: constants of the repair-header host controller.
// assumes one 100 MHz clock and 32-bit packet words.
`default_nettype none
package ffh_pkg;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_RECOV  = 8'h04;
	localparam logic [7:0] A_TSREC  = 8'h08;
	localparam logic [7:0] A_RTPCFG = 8'h0C;
	localparam logic [7:0] A_SEQ    = 8'h10;
	localparam logic [7:0] A_SSRC   = 8'h14;
	localparam logic [7:0] A_MASKSZ = 8'h18;
	localparam logic [7:0] A_STATUS = 8'h1C;
	localparam logic [7:0] A_RXW0   = 8'h20;
	localparam logic [7:0] A_RXW1   = 8'h24;
	localparam logic [7:0] A_RXTS   = 8'h28;
	localparam logic [7:0] A_RXBLK  = 8'h2C;
	localparam logic [7:0] A_RXCNT  = 8'h30;
	localparam logic [7:0] A_RXINFO = 8'h34;
	localparam logic [7:0] A_RXCSRC = 8'h38;
	localparam int         STRM_BASE   = 32'h40;
	localparam int         STRM_STRIDE = 32'h20;
	localparam int         STRM_WORDS  = 32'h5;
	localparam int         W_SSRC      = 32'h4;
	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int         CTRL_GO      = 0;
	localparam int         CTRL_TOP_LSB = 1;
	localparam int         CTRL_FIX     = 3;
	localparam int         REC_LSB      = 0;
	localparam int         REC_LOW_LSB  = 16;
	localparam int         CFG_PT_LSB   = 0;
	localparam int         CFG_NSTR_LSB = 8;
	localparam int         ST_TXBUSY    = 0;
	localparam int         ST_RXDONE    = 1;
	localparam int         ST_RXDROP    = 2;
	localparam logic [31:0] RST_REG     = 32'h0;
	localparam logic [1:0] RTP_VER      = 2'h2;
	localparam logic [2:0] HSIZE_WORD   = 3'h2;
	// ----------------------------------------------------------------
	// protection types and mask sizes
	// ----------------------------------------------------------------
	localparam logic [1:0] TOP_COL  = 2'h0;
	localparam logic [1:0] TOP_ROW  = 2'h1;
	localparam logic [1:0] TOP_2D   = 2'h2;
	localparam logic [1:0] TOP_RETX = 2'h3;
	localparam logic [1:0] MSZ_15   = 2'h0;
	localparam logic [1:0] MSZ_46   = 2'h1;
	localparam logic [1:0] MSZ_110  = 2'h2;
	// ----------------------------------------------------------------
	// state machines
	// ----------------------------------------------------------------
	typedef enum logic [7:0] {
		TX_IDLE = 8'h01, TX_RTP = 8'h02, TX_CSRC = 8'h04, TX_FEC0 = 8'h08,
		TX_FEC1 = 8'h10, TX_FEC2 = 8'h20, TX_BLK  = 8'h40, TX_PAY  = 8'h80
	} ffh_txs_t;
	typedef enum logic [8:0] {
		RX_HDR  = 9'h001, RX_RTP  = 9'h002, RX_CSRC = 9'h004, RX_FEC0 = 9'h008,
		RX_FEC1 = 9'h010, RX_FEC2 = 9'h020, RX_BLK  = 9'h040, RX_PAY  = 9'h080,
		RX_DROP = 9'h100
	} ffh_rxs_t;
endpackage : ffh_pkg
`default_nettype wire

// [rtl/ffh_ahb_port.sv]
// ffh_ahb_port: AHB-Lite slave for the host registers.
// assumes single word transfers; reads take one wait state, writes none.
`default_nettype none
module ffh_ahb_port (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// register side
	output logic      [7:0]  regAddr,
	output logic             regWr,
	output logic      [31:0] regWdata,
	input  wire logic [31:0] rdData
);
	typedef struct packed {
		logic [7:0]  addr;
		logic        hit;
		logic        wrPend;
		logic        rdPend;
		logic [31:0] hrdata;
		logic        hreadyout;
	} ffh_ahb_t;

	ffh_ahb_t r, n;
	logic     accept;

	// ----------------------------------------------------------------
	// address and data phase tracking
	// ----------------------------------------------------------------
	always_comb begin
		n = r;
		accept = hsel && htrans[1] && hready;
		n.wrPend = 1'b0;
		n.rdPend = 1'b0;
		if (accept) begin
			n.addr = {haddr[7:2], 2'b00};
			// addresses past the map, or partial words, read zero and drop writes
			n.hit = (haddr[31:8] == 24'h0) && (hsize == ffh_pkg::HSIZE_WORD);
			n.wrPend = hwrite;
			n.rdPend = !hwrite;
			n.hreadyout = hwrite;
		end
		if (r.rdPend) begin
			n.hrdata = r.hit ? rdData : 32'h0;
			n.hreadyout = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			r.hreadyout <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign hrdata = r.hrdata;
	assign hreadyout = r.hreadyout;
	assign hresp = 1'b0;
	assign regAddr = r.addr;
	assign regWr = r.wrPend && r.hit;
	assign regWdata = hwdata;
endmodule : ffh_ahb_port
`default_nettype wire

// [rtl/ffh_host.sv]
// ffh_host: host controller that frames and parses parity repair packets.
// assumes a same-clock packet datapath and software on AHB-Lite.
//
// Notes on behaviour
// R1: R=0,F=0 selects the flexible mask header
// R2: R=0,F=1 carries column and row counts
// R3: never send R=F=1; receiver drops it
// R4: R is 1 for retransmission, else 0
// R5: F forced zero when R is one
// R6: recovery fields rebuild P, X, CC, M, PT
// R7: length recovery counts octets past twelve bytes
// R8: timestamp recovery rebuilds the source timestamp
// R9: one base-and-mask block per listed stream
// R10: base is lowest protected number, wrapping
// R11: mask bit j protects base plus j
// R12: k bit chains mask chunks 15/46/110
// R13: payload repairs everything past fixed header
// R14: fixed variant repeats base, L, D per stream
// R15: zero L and D use session values
// R16: L>0, D=0 means row protection only
// R17: D=1 sends all rows before columns
// R18: D>1 means column protection, stride L
// R19: retransmission carries sequence, SSRC in header
// R20: retransmission prepends header to source packet
// R21: protection type 0 col,1 row,2 2D,3 retx
// R22: every packet uses RTP version two
// R23: marker sent zero, ignored when received
// R24: CSRC list names protected streams
// R25: repair sequence number steps by one
// R26: recovery by XOR with zero padding
`default_nettype none
module ffh_host #(
	parameter int NSTR = 2
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// repair payload in
	input  wire logic [31:0] payData,
	input  wire logic        payValid,
	input  wire logic        payLast,
	output logic             payReady,
	// packet out
	output logic      [31:0] txData,
	output logic             txValid,
	output logic             txLast,
	input  wire logic        txReady,
	// packet in
	input  wire logic [31:0] rxData,
	input  wire logic        rxValid,
	input  wire logic        rxLast
);
	typedef struct packed {
		ffh_pkg::ffh_txs_t                 txs;
		ffh_pkg::ffh_rxs_t                 rxs;
		logic [31:0]                       ctrl;
		logic [31:0]                       recov;
		logic [31:0]                       tsRec;
		logic [31:0]                       rtpCfg;
		logic [31:0]                       seq;
		logic [31:0]                       ssrc;
		logic [31:0]                       maskSz;
		logic [31:0]                       tick;
		logic [NSTR-1:0][4:0][31:0]        strm;
		logic [3:0]                        idx;
		logic [1:0]                        chunk;
		logic [31:0]                       txData;
		logic                              txValid;
		logic                              txLast;
		logic                              payReady;
		logic [3:0]                        rxIdx;
		logic [3:0]                        rxCc;
		logic [1:0]                        rxChunk;
		logic [3:0]                        rxBlocks;
		logic [15:0]                       rxWords;
		logic [31:0]                       rxW0;
		logic [31:0]                       rxW1;
		logic [31:0]                       rxTs;
		logic [31:0]                       rxBlk0;
		logic [31:0]                       rxCsrc;
		logic [15:0]                       goodCnt;
		logic [15:0]                       dropCnt;
		logic                              rxDone;
		logic                              rxDrop;
	} ffh_state_t;

	ffh_state_t  r, n;
	logic [7:0]  regAddr;
	logic        regWr;
	logic [31:0] regWdata;
	logic [31:0] rdData;
	logic        slotFree, emit, eLast, retx, fix, rxEnd, sLast;
	logic [31:0] eWord;
	logic [3:0]  nStr;
	logic [1:0]  sz;
	int          sI;

	ffh_ahb_port u_port (
		.clk       (clk),
		.nrst      (nrst),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.regAddr   (regAddr),
		.regWr     (regWr),
		.regWdata  (regWdata),
		.rdData    (rdData)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] strmAddr(input int s, input int w);
		return 8'(ffh_pkg::STRM_BASE + s * ffh_pkg::STRM_STRIDE + w * 4);
	endfunction : strmAddr

	// mask chunk c of one stream; the k bit says whether another follows
	function automatic logic chunkLast(input logic f, input logic [1:0] s, input logic [1:0] c);
		if (f)
			return 1'b1;
		case (c)
			2'h0:    return s == ffh_pkg::MSZ_15;
			2'h1:    return s == ffh_pkg::MSZ_46;
			2'h2:    return 1'b0;
			default: return 1'b1;
		endcase
	endfunction : chunkLast

	// ----------------------------------------------------------------
	// register read mux
	// ----------------------------------------------------------------
	always_comb begin
		rdData = 32'h0;
		case (regAddr)
			ffh_pkg::A_CTRL:   rdData = r.ctrl;
			ffh_pkg::A_RECOV:  rdData = r.recov;
			ffh_pkg::A_TSREC:  rdData = r.tsRec;
			ffh_pkg::A_RTPCFG: rdData = r.rtpCfg;
			ffh_pkg::A_SEQ:    rdData = r.seq;
			ffh_pkg::A_SSRC:   rdData = r.ssrc;
			ffh_pkg::A_MASKSZ: rdData = r.maskSz;
			ffh_pkg::A_STATUS: rdData = {29'h0, r.rxDrop, r.rxDone, r.txs != ffh_pkg::TX_IDLE};
			ffh_pkg::A_RXW0:   rdData = r.rxW0;
			ffh_pkg::A_RXW1:   rdData = r.rxW1;
			ffh_pkg::A_RXTS:   rdData = r.rxTs;
			ffh_pkg::A_RXBLK:  rdData = r.rxBlk0;
			ffh_pkg::A_RXCNT:  rdData = {r.dropCnt, r.goodCnt};
			ffh_pkg::A_RXINFO: rdData = {12'h0, r.rxBlocks, r.rxWords};
			ffh_pkg::A_RXCSRC: rdData = r.rxCsrc;
			default: begin
				for (int s = 0; s < NSTR; s++)
					for (int w = 0; w < ffh_pkg::STRM_WORDS; w++)
						if (regAddr == strmAddr(s, w))
							rdData = r.strm[s][w];
			end
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		n = r;
		emit = 1'b0;
		eWord = 32'h0;
		eLast = 1'b0;
		slotFree = !r.txValid || txReady;
		nStr = r.rtpCfg[ffh_pkg::CFG_NSTR_LSB +: 4];
		retx = r.ctrl[ffh_pkg::CTRL_TOP_LSB +: 2] == ffh_pkg::TOP_RETX; // [R21]
		fix = r.ctrl[ffh_pkg::CTRL_FIX] && !retx; // [R5]
		sI = (int'(r.idx) < NSTR) ? int'(r.idx) : 0;
		sz = r.maskSz[{r.idx, 1'b0} +: 2];
		sLast = chunkLast(fix, sz, r.chunk);
		n.tick = r.tick + 32'h1;
		// software writes; go is a self-clearing strobe
		if (regWr) begin
			case (regAddr)
				ffh_pkg::A_CTRL:   n.ctrl = regWdata & ~(32'h1 << ffh_pkg::CTRL_GO);
				ffh_pkg::A_RECOV:  n.recov = regWdata;
				ffh_pkg::A_TSREC:  n.tsRec = regWdata;
				ffh_pkg::A_RTPCFG: n.rtpCfg = regWdata;
				ffh_pkg::A_SEQ:    n.seq = regWdata;
				ffh_pkg::A_SSRC:   n.ssrc = regWdata;
				ffh_pkg::A_MASKSZ: n.maskSz = regWdata;
				ffh_pkg::A_STATUS: begin
					if (regWdata[ffh_pkg::ST_RXDONE])
						n.rxDone = 1'b0;
					if (regWdata[ffh_pkg::ST_RXDROP])
						n.rxDrop = 1'b0;
				end
				default: begin
					for (int s = 0; s < NSTR; s++)
						for (int w = 0; w < ffh_pkg::STRM_WORDS; w++)
							if (regAddr == strmAddr(s, w))
								n.strm[s][w] = regWdata;
				end
			endcase
		end
		// transmit framer
		case (r.txs)
			ffh_pkg::TX_IDLE: begin
				if (regWr && regAddr == ffh_pkg::A_CTRL && regWdata[ffh_pkg::CTRL_GO]) begin
					n.txs = ffh_pkg::TX_RTP;
					n.idx = 4'h0;
				end
			end
			ffh_pkg::TX_RTP: begin
				if (slotFree) begin
					emit = 1'b1;
					case (r.idx)
						// marker zero; CSRC count names the streams
						4'h0:    eWord = {ffh_pkg::RTP_VER, 2'b00, retx ? 4'h0 : nStr, 1'b0,
							r.rtpCfg[ffh_pkg::CFG_PT_LSB +: 7], r.seq[15:0]}; // [R22] [R23] [R24]
						4'h1:    eWord = r.tick;
						default: eWord = r.ssrc;
					endcase
					n.idx = r.idx + 4'h1;
					if (r.idx == 4'h2) begin
						n.idx = 4'h0;
						n.txs = (retx || nStr == 4'h0) ? ffh_pkg::TX_FEC0 : ffh_pkg::TX_CSRC;
					end
				end
			end
			ffh_pkg::TX_CSRC: begin
				if (slotFree) begin
					emit = 1'b1;
					eWord = r.strm[sI][ffh_pkg::W_SSRC]; // [R24]
					n.idx = r.idx + 4'h1;
					if (r.idx == nStr - 4'h1) begin
						n.idx = 4'h0;
						n.txs = ffh_pkg::TX_FEC0;
					end
				end
			end
			ffh_pkg::TX_FEC0: begin
				if (slotFree) begin
					emit = 1'b1;
					// R and F never both one; low half is length, or sequence when resending
					eWord = {retx, fix, r.recov[ffh_pkg::REC_LSB +: 14],
						r.recov[ffh_pkg::REC_LOW_LSB +: 16]}; // [R1] [R2] [R3] [R4] [R6] [R7] [R19] [R26]
					n.txs = ffh_pkg::TX_FEC1;
				end
			end
			ffh_pkg::TX_FEC1: begin
				if (slotFree) begin
					emit = 1'b1;
					eWord = r.tsRec; // [R8]
					if (retx)
						n.txs = ffh_pkg::TX_FEC2;
					else
						n.txs = (nStr == 4'h0) ? ffh_pkg::TX_PAY : ffh_pkg::TX_BLK;
				end
			end
			ffh_pkg::TX_FEC2: begin
				if (slotFree) begin
					emit = 1'b1;
					eWord = r.strm[0][ffh_pkg::W_SSRC]; // [R19]
					n.txs = ffh_pkg::TX_PAY;
				end
			end
			ffh_pkg::TX_BLK: begin
				if (slotFree) begin
					emit = 1'b1;
					// base and L/D, or base and first chunk with its k bit
					case (r.chunk)
						2'h0: eWord = fix ? r.strm[sI][0] : {r.strm[sI][0][31:16], !sLast,
							r.strm[sI][0][14:0]}; // [R2] [R10] [R11] [R12] [R14] [R15] [R16] [R17] [R18]
						2'h1: eWord = {!sLast, r.strm[sI][1][30:0]}; // [R12]
						2'h2: eWord = r.strm[sI][2];
						default: eWord = r.strm[sI][3];
					endcase
					n.chunk = r.chunk + 2'h1;
					if (sLast) begin
						n.chunk = 2'h0;
						n.idx = r.idx + 4'h1;
						if (r.idx == nStr - 4'h1)
							n.txs = ffh_pkg::TX_PAY; // [R9]
					end
				end
			end
			ffh_pkg::TX_PAY: begin
				if (payValid && r.payReady) begin
					emit = 1'b1;
					eWord = payData; // [R13] [R20]
					eLast = payLast;
					if (payLast) begin
						n.txs = ffh_pkg::TX_IDLE;
						n.seq = r.seq + 32'h1; // [R25]
					end
				end
			end
			default: n.txs = ffh_pkg::TX_IDLE;
		endcase
		if (emit) begin
			n.txData = eWord;
			n.txValid = 1'b1;
			n.txLast = eLast;
		end else if (txReady) begin
			n.txValid = 1'b0;
		end
		// one output register and no skid: payload moves at most every other cycle
		n.payReady = (n.txs == ffh_pkg::TX_PAY) && !n.txValid;
		// receive parser
		rxEnd = rxValid && rxLast;
		if (rxValid) begin
			n.rxWords = r.rxWords + 16'h1;
			case (r.rxs)
				ffh_pkg::RX_HDR: begin
					n.rxWords = 16'h1;
					n.rxBlocks = 4'h0;
					n.rxIdx = 4'h0;
					n.rxChunk = 2'h0;
					n.rxCc = rxData[27:24]; // [R24]
					// the marker bit is not looked at
					n.rxs = (rxData[31:30] == ffh_pkg::RTP_VER) ? ffh_pkg::RX_RTP
						: ffh_pkg::RX_DROP; // [R22] [R23]
				end
				ffh_pkg::RX_RTP: begin
					n.rxIdx = r.rxIdx + 4'h1;
					if (r.rxIdx == 4'h1) begin
						n.rxIdx = 4'h0;
						n.rxs = (r.rxCc == 4'h0) ? ffh_pkg::RX_FEC0 : ffh_pkg::RX_CSRC;
					end
				end
				ffh_pkg::RX_CSRC: begin
					if (r.rxIdx == 4'h0)
						n.rxCsrc = rxData;
					n.rxIdx = r.rxIdx + 4'h1;
					if (r.rxIdx == r.rxCc - 4'h1) begin
						n.rxIdx = 4'h0;
						n.rxs = ffh_pkg::RX_FEC0;
					end
				end
				ffh_pkg::RX_FEC0: begin
					n.rxW0 = rxData;
					n.rxW1 = {16'h0, rxData[15:0]};
					n.rxs = (rxData[31] && rxData[30]) ? ffh_pkg::RX_DROP
						: ffh_pkg::RX_FEC1; // [R3]
				end
				ffh_pkg::RX_FEC1: begin
					n.rxTs = rxData;
					if (r.rxW0[31])
						n.rxs = ffh_pkg::RX_FEC2; // [R4] [R19]
					else
						n.rxs = (r.rxCc == 4'h0) ? ffh_pkg::RX_PAY : ffh_pkg::RX_BLK;
				end
				ffh_pkg::RX_FEC2: begin
					n.rxCsrc = rxData; // [R19]
					n.rxs = ffh_pkg::RX_PAY;
				end
				ffh_pkg::RX_BLK: begin
					if (r.rxIdx == 4'h0 && r.rxChunk == 2'h0)
						n.rxBlk0 = rxData; // [R10]
					n.rxChunk = r.rxChunk + 2'h1;
					// fixed variant is one word a stream; masks follow their k bits
					if (r.rxW0[30] || (r.rxChunk == 2'h0 && !rxData[15])
						|| (r.rxChunk == 2'h1 && !rxData[31])
						|| r.rxChunk == 2'h3) begin // [R1] [R2] [R12] [R14]
						n.rxChunk = 2'h0;
						n.rxBlocks = r.rxBlocks + 4'h1;
						n.rxIdx = r.rxIdx + 4'h1;
						if (r.rxIdx == r.rxCc - 4'h1)
							n.rxs = ffh_pkg::RX_PAY; // [R9]
					end
				end
				ffh_pkg::RX_PAY: n.rxs = ffh_pkg::RX_PAY; // [R13]
				ffh_pkg::RX_DROP: n.rxs = ffh_pkg::RX_DROP;
				default: n.rxs = ffh_pkg::RX_HDR;
			endcase
			if (rxEnd) begin
				// a packet that ends before its last header word counts as dropped
				if (r.rxs == ffh_pkg::RX_PAY || n.rxs == ffh_pkg::RX_PAY) begin
					n.goodCnt = r.goodCnt + 16'h1;
					n.rxDone = 1'b1;
				end else begin
					n.dropCnt = r.dropCnt + 16'h1;
					n.rxDrop = 1'b1;
				end
				n.rxs = ffh_pkg::RX_HDR;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			r.txs <= ffh_pkg::TX_IDLE;
			r.rxs <= ffh_pkg::RX_HDR;
		end else begin
			r <= n;
		end
	end

	assign txData = r.txData;
	assign txValid = r.txValid;
	assign txLast = r.txLast;
	assign payReady = r.payReady;
endmodule : ffh_host
`default_nettype wire

// [verif/ffh_host_chk.sv]
// ffh_host_chk: port assertions for the repair-header host controller.
// assumes a bind onto ffh_host.
`default_nettype none
module ffh_host_chk #(
	parameter int NSTR = 2
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// ahb-lite
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// payload and packets
	input wire logic        payValid,
	input wire logic        payReady,
	input wire logic [31:0] txData,
	input wire logic        txValid,
	input wire logic        txLast,
	input wire logic        txReady
);
	// ----------------------------------------------------------------
	// word position within the outgoing packet
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0]  idx;
		logic [3:0]  cc;
		logic [15:0] seq;
		logic        seen;
	} ffh_chk_t;
	ffh_chk_t st_r, st_nxt;
	logic     txMove, sop, fecWord;
	assign txMove  = txValid && txReady;
	assign sop     = txValid && (st_r.idx == 5'h00);
	assign fecWord = txValid && (st_r.idx == {1'b0, st_r.cc} + 5'h03);
	always_comb begin
		st_nxt = st_r;
		if (txMove && sop) begin
			st_nxt.cc   = txData[27:24];
			st_nxt.seq  = txData[15:0];
			st_nxt.seen = 1'b1;
		end
		// saturate so long payloads never alias the header positions
		if (txMove && txLast)
			st_nxt.idx = 5'h00;
		else if (txMove && st_r.idx != 5'h1F)
			st_nxt.idx = st_r.idx + 5'h01;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence rdAddr;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence rdWait;
		!hreadyout ##1 hreadyout;
	endsequence
	a_read_wait: assert property (rdAddr |=> rdWait)
		else $error("read wait state wrong");
	a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
		else $error("write stalled");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response");
	a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast))
		else $error("tx word changed");
	a_rtp_version: assert property (sop |-> txData[31:30] == ffh_pkg::RTP_VER)
		else $error("bad rtp version");
	a_marker_zero: assert property (sop |-> !txData[23])
		else $error("marker set");
	a_rf_legal: assert property (fecWord |-> !(txData[31] && txData[30]))
		else $error("both r and f set");
	a_retx_nocsrc: assert property (fecWord && txData[31] |-> st_r.cc == 4'h0)
		else $error("retx with csrc");
	a_seq_step: assert property (sop && st_r.seen |-> txData[15:0] == st_r.seq + 16'h0001)
		else $error("sequence not stepped");
	a_pay_pulse: assert property (payReady && payValid |=> !payReady)
		else $error("payload ready held");
endmodule : ffh_host_chk
bind ffh_host ffh_host_chk #(.NSTR(NSTR)) chk_u (
	.clk, .nrst, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .payValid,
	.payReady, .txData, .txValid, .txLast, .txReady
);
`default_nettype wire

// [verif/ffh_peer.sv]
// ffh_peer: remote endpoint; sinks repair packets and sends packets in.
// assumes sendPkt is called just after a rising edge.
`default_nettype none
module ffh_peer (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// stall select
	input  wire logic        slow,
	// packets from the controller
	input  wire logic [31:0] txData,
	input  wire logic        txValid,
	input  wire logic        txLast,
	output logic             txReady,
	// packets to the controller
	output logic      [31:0] rxData,
	output logic             rxValid,
	output logic             rxLast
);
	logic [31:0] got [$];
	int          pkts;
	initial begin
		pkts    = 0;
		rxData  = 32'h0;
		rxValid = 1'b0;
		rxLast  = 1'b0;
	end
	// slow mode stalls every other cycle
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			txReady <= 1'b0;
		end else begin
			txReady <= slow ? !txReady : 1'b1;
			if (txValid && txReady) begin
				got.push_back(txData);
				if (txLast) pkts++;
			end
		end
	end
	task automatic sendPkt(input logic [31:0] w [10], input int n);
		for (int i = 0; i < n; i++) begin
			rxData  <= w[i];
			rxValid <= 1'b1;
			rxLast  <= (i == n - 1);
			@(posedge clk);
		end
		rxValid <= 1'b0;
		rxLast  <= 1'b0;
		// released line shows the inverse
		rxData  <= ~w[n - 1];
	endtask : sendPkt
endmodule : ffh_peer
`default_nettype wire

// [verif/test_flexible_fec_header_codec.sv]
// test_flexible_fec_header_codec: self-checking bench for ffh_host.
// assumes ffh_peer as far side; hready is looped back from hreadyout.
`default_nettype none
module test_flexible_fec_header_codec;
	timeunit 1ns;
	timeprecision 1ns;
	typedef logic [31:0] ffh_words_t [10];
	logic        clk, nrst, hsel, hwrite, payValid, payLast, slow;
	logic [31:0] haddr, hwdata, payData;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	wire  logic [31:0] hrdata, txData, rxData;
	wire  logic        hreadyout, hresp, payReady, txValid, txLast, txReady, rxValid, rxLast;
	int          failures, samplesChecked, cycles;
	ffh_words_t  e;
	ffh_host #(.NSTR(2)) dut_u (
		.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hrdata, .hreadyout, .hresp, .payData, .payValid, .payLast, .payReady, .txData,
		.txValid, .txLast, .txReady, .rxData, .rxValid, .rxLast
	);
	ffh_peer peer_u (
		.clk, .nrst, .slow, .txData, .txValid, .txLast, .txReady, .rxData, .rxValid, .rxLast
	);
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= ffh_pkg::HSIZE_WORD;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : ahb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask : wr
	task automatic rdChk(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		ahb(1'b0, a, 32'h0, q);
		check(q, x);
	endtask : rdChk
	// word 1 is the free-running timestamp: not compared
	task automatic txPkt(input logic [31:0] ctrl, input int n);
		int p;
		p = peer_u.pkts;
		peer_u.got.delete();
		wr(ffh_pkg::A_CTRL, ctrl);
		payData  <= e[n - 1];
		payValid <= 1'b1;
		payLast  <= 1'b1;
		do @(posedge clk); while (payReady !== 1'b1);
		payValid <= 1'b0;
		payLast  <= 1'b0;
		payData  <= ~e[n - 1];
		while (peer_u.pkts == p) @(posedge clk);
		check(32'(peer_u.got.size()), 32'(n));
		for (int i = 0; i < n; i++) begin
			if (i != 1) check(peer_u.got[i], e[i]);
		end
	endtask : txPkt
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic testReset;
		logic [7:0] regs [5] = '{ffh_pkg::A_CTRL, ffh_pkg::A_STATUS, ffh_pkg::A_RXCNT,
			ffh_pkg::A_SEQ, 8'hFC};
		check({31'h0, txValid}, 32'h0);
		foreach (regs[i]) rdChk(regs[i], ffh_pkg::RST_REG);
		$display("test reset done");
	endtask : testReset
	task automatic testTx;
		wr(ffh_pkg::A_RTPCFG, 32'h160);
		wr(ffh_pkg::A_SSRC, 32'hA5A50001);
		wr(ffh_pkg::A_SEQ, 32'hFFFF);
		wr(ffh_pkg::A_RECOV, 32'h01232A55);
		wr(ffh_pkg::A_TSREC, 32'h12345678);
		wr(8'h40, 32'h10004001);
		wr(8'h50, 32'hC0DE0001);
		e = '{32'h8160FFFF, 32'h0, 32'hA5A50001, 32'hC0DE0001, 32'h2A550123, 32'h12345678,
			32'h10004001, 32'hDA7A0007, 32'h0, 32'h0};
		txPkt(32'h1, 8);
		slow <= 1'b1;
		wr(ffh_pkg::A_MASKSZ, 32'h1);
		wr(8'h44, 32'h5);
		e[0] = 32'h81600000;
		e[6] = 32'h1000C001;
		e[7] = 32'h5;
		e[8] = 32'hDA7A0008;
		txPkt(32'h1, 9);
		slow <= 1'b0;
		wr(ffh_pkg::A_MASKSZ, 32'h0);
		wr(8'h40, 32'h10000402);
		e[0] = 32'h81600001;
		e[4] = 32'h6A550123;
		e[6] = 32'h10000402;
		e[7] = 32'hDA7A0009;
		txPkt(32'h9, 8);
		e = '{32'h80600002, 32'h0, 32'hA5A50001, 32'hAA550123, 32'h12345678, 32'hC0DE0001,
			32'hDA7A000A, 32'h0, 32'h0, 32'h0};
		txPkt(32'hF, 7);
		$display("test tx done");
	endtask : testTx
	task automatic testRx;
		e = '{32'h81E00042, 32'h100, 32'h55550002, 32'hC0DE0009, 32'h2A550123, 32'h12345678,
			32'h20000003, 32'hDEAD0001, 32'h0, 32'h0};
		peer_u.sendPkt(e, 8);
		rdChk(ffh_pkg::A_RXCNT, 32'h1);
		rdChk(ffh_pkg::A_RXW0, 32'h2A550123);
		rdChk(ffh_pkg::A_RXTS, 32'h12345678);
		rdChk(ffh_pkg::A_RXBLK, 32'h20000003);
		rdChk(ffh_pkg::A_RXCSRC, 32'hC0DE0009);
		e[4] = 32'hEA550123;
		peer_u.sendPkt(e, 8);
		rdChk(ffh_pkg::A_RXCNT, 32'h10001);
		e[0] = 32'h41E00042;
		e[4] = 32'h2A550123;
		peer_u.sendPkt(e, 8);
		rdChk(ffh_pkg::A_RXCNT, 32'h20001);
		rdChk(ffh_pkg::A_STATUS, 32'h6);
		wr(ffh_pkg::A_STATUS, 32'h6);
		rdChk(ffh_pkg::A_STATUS, 32'h0);
		$display("test rx done");
	endtask : testRx
	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samplesChecked, failures);
		if (failures == 0 && samplesChecked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end
	initial begin
		{nrst, hsel, hwrite, payValid, payLast, slow} = 6'h0;
		{haddr, hwdata, payData, htrans, hsize} = '0;
		{failures, samplesChecked, cycles} = '0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		testReset();
		testTx();
		testRx();
		print_verdict();
	end
endmodule : test_flexible_fec_header_codec
`default_nettype wire
